// file: inc/boost_jump_pkg.sv
package boost_jump_pkg;

  // ------------------------------------------------------------
  // Register map, word aligned byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] ADR_CONFIG = 8'h00;
  localparam logic [7:0] ADR_INITIAL = 8'h04;
  localparam logic [7:0] ADR_BRIGHTNESS = 8'h08;
  localparam logic [7:0] ADR_CLUSTER = 8'h0c;
  localparam logic [7:0] ADR_STATUS = 8'h10;

  // ------------------------------------------------------------
  // Field layout and reset values
  // ------------------------------------------------------------
  typedef struct packed {
    logic [1:0] driver_size;
    logic adaptive_setpoint_enable;
    logic jump_enable;
    logic [1:0] luminance_change_threshold;
    logic [1:0] jump_step_size;
  } config_s;

  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [5:0] INITIAL_RESET = 6'h00;
  localparam logic [3:0] CLUSTER_RESET = 4'h0;
  localparam int unsigned NUM_STRINGS = 4;

  // Setpoint counts fine steps of 0.125 V above 16 V;
  // one initial-voltage code (0.5 V) is four fine steps
  localparam int unsigned CODE_SHIFT = 2;
  localparam logic [7:0] SETPOINT_MAX = 8'hfc;

  // Jump sizes in fine steps, per step-size code
  localparam logic [7:0] JUMP_STEPS_0 = 8'h08;
  localparam logic [7:0] JUMP_STEPS_1 = 8'h10;
  localparam logic [7:0] JUMP_STEPS_2 = 8'h20;
  localparam logic [7:0] JUMP_STEPS_3 = 8'h40;

  // Brightness thresholds as percent of full scale
  localparam int unsigned FULL_SCALE = 65535;
  localparam int unsigned THRES_PCT_0 = 10;
  localparam int unsigned THRES_PCT_1 = 30;
  localparam int unsigned THRES_PCT_2 = 50;
  localparam int unsigned THRES_PCT_3 = 70;
  localparam logic [15:0] THRES_0 = 16'(FULL_SCALE * THRES_PCT_0 / 100);
  localparam logic [15:0] THRES_1 = 16'(FULL_SCALE * THRES_PCT_1 / 100);
  localparam logic [15:0] THRES_2 = 16'(FULL_SCALE * THRES_PCT_2 / 100);
  localparam logic [15:0] THRES_3 = 16'(FULL_SCALE * THRES_PCT_3 / 100);

  // ------------------------------------------------------------
  // Timing: adaptive loop takes one fine step per period
  // ------------------------------------------------------------
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned ADAPT_PERIOD_NS = 1000;
  localparam int unsigned ADAPT_CYCLES =
    (ADAPT_PERIOD_NS * (CLK_HZ / 1000000)) / 1000;
  localparam logic [7:0] ADAPT_LAST = 8'(ADAPT_CYCLES - 1);

  // Gate driver segment enables, ascending strength
  localparam logic [2:0] DRIVE_0 = 3'h0;
  localparam logic [2:0] DRIVE_1 = 3'h1;
  localparam logic [2:0] DRIVE_2 = 3'h3;
  localparam logic [2:0] DRIVE_3 = 3'h7;

endpackage

// file: rtl/pin_filter.sv
`timescale 1ns/1ns
`default_nettype none

module pin_filter
#(
  parameter int unsigned WIDTH = 8
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] level_o
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // ------------------------------------------------------------
  // Four flops per bit, level accepted once two and three agree
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : bit_sync
      // Stage one feeds stage two only, for metastability
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          stage1[g] <= 1'b0;
          stage2[g] <= 1'b0;
          stage3[g] <= 1'b0;
          level_o[g] <= 1'b0;
        end
        else
        begin
          stage1[g] <= pin_i[g];
          stage2[g] <= stage1[g];
          stage3[g] <= stage2[g];
          if (stage2[g] == stage3[g])
            level_o[g] <= stage3[g];
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// file: rtl/boost_jump_ctrl.sv
// How it works
// - Adaptive off: hold setpoint at initial code
// - Adaptive on: start at code, track strings
// - All strings clustered forces adaptive off
// - Jump only when jump enable set
// - Jump when brightness rise exceeds threshold
// - Jump adds 8, 16, 32 or 64 steps
// - Driver size decodes to ascending strength
// - Initial code: 16 V plus 0.5 V steps
//
// Decided for this implementation: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none

module boost_jump_ctrl
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [boost_jump_pkg::NUM_STRINGS-1:0] headroom_low_i,
  input wire logic [boost_jump_pkg::NUM_STRINGS-1:0] headroom_high_i,
  output logic [7:0] setpoint_o,
  output logic adaptive_active_o,
  output logic jump_o,
  output logic [2:0] drive_enable_o
);
  import boost_jump_pkg::*;

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  config_s cfg;
  logic [5:0] initial_code;
  logic [15:0] brightness;
  logic [15:0] brightness_ref;
  logic [3:0] cluster_mode;
  logic [7:0] adapt_count;
  logic adapt_tick;
  logic adaptive_on;
  logic [7:0] start_point;
  logic [2*NUM_STRINGS-1:0] pins_level;
  logic any_low;
  logic all_high;
  logic access;
  logic write_now;
  logic [15:0] next_brightness;
  logic [15:0] thres;
  logic [7:0] jump_steps;
  logic [8:0] jump_sum;
  logic jump_hit;
  logic [31:0] next_rdata;

  // ------------------------------------------------------------
  // Headroom pins from the analog sinks
  // ------------------------------------------------------------
  pin_filter #(
    .WIDTH(2 * NUM_STRINGS)
  ) u_pins (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i({headroom_high_i, headroom_low_i}),
    .level_o(pins_level)
  );

  assign any_low = |pins_level[NUM_STRINGS-1:0];
  assign all_high = &pins_level[2*NUM_STRINGS-1:NUM_STRINGS];

  // ------------------------------------------------------------
  // Wishbone slave
  // ------------------------------------------------------------
  // Writes land on the edge where ack is high, as the master sees it
  assign access = wb_cyc_i & wb_stb_i;
  assign write_now = access & wb_we_i & wb_ack_o;

  // Single wait state; ack drops the cycle after it rises
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= access & ~wb_ack_o;
  end

  // Read mux; unmapped offsets answer with zero
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    unique case (wb_adr_i)
      ADR_CONFIG:
        next_rdata[7:0] = cfg;
      ADR_INITIAL:
        next_rdata[5:0] = initial_code;
      ADR_BRIGHTNESS:
        next_rdata[15:0] = brightness;
      ADR_CLUSTER:
        next_rdata[3:0] = cluster_mode;
      ADR_STATUS:
        next_rdata[15:0] = {6'h00, jump_o, adaptive_on, setpoint_o};
      default:
        next_rdata = 32'h0000_0000;
    endcase
  end

  // Read data caught as ack rises, held through the ack cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= 32'h0000_0000;
    else if (access & ~wb_ack_o)
      wb_dat_o <= next_rdata;
  end

  // ------------------------------------------------------------
  // Software registers
  // ------------------------------------------------------------
  // Configuration, initial code and cluster map
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cfg <= CONFIG_RESET;
      initial_code <= INITIAL_RESET;
      cluster_mode <= CLUSTER_RESET;
    end
    else if (write_now & wb_sel_i[0])
    begin
      if (wb_adr_i == ADR_CONFIG)
        cfg <= wb_dat_i[7:0];
      if (wb_adr_i == ADR_INITIAL)
        initial_code <= wb_dat_i[5:0];
      if (wb_adr_i == ADR_CLUSTER)
        cluster_mode <= wb_dat_i[3:0];
    end
  end

  // Brightness takes byte lanes so a half update is possible
  always_comb
  begin
    next_brightness = brightness;
    if (wb_sel_i[0])
      next_brightness[7:0] = wb_dat_i[7:0];
    if (wb_sel_i[1])
      next_brightness[15:8] = wb_dat_i[15:8];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      brightness <= 16'h0000;
    else if (write_now && wb_adr_i == ADR_BRIGHTNESS)
      brightness <= next_brightness;
  end

  // ------------------------------------------------------------
  // Mode and jump decode
  // ------------------------------------------------------------
  // Clustered strings have no common rail to track
  assign adaptive_on = cfg.adaptive_setpoint_enable
    & ~(&cluster_mode);

  // 16 V at code zero, 0.5 V per code, four fine steps each
  assign start_point = 8'(initial_code) << CODE_SHIFT;

  always_comb
  begin
    unique case (cfg.luminance_change_threshold)
      2'b00: thres = THRES_0;
      2'b01: thres = THRES_1;
      2'b10: thres = THRES_2;
      2'b11: thres = THRES_3;
    endcase
  end

  always_comb
  begin
    unique case (cfg.jump_step_size)
      2'b00: jump_steps = JUMP_STEPS_0;
      2'b01: jump_steps = JUMP_STEPS_1;
      2'b10: jump_steps = JUMP_STEPS_2;
      2'b11: jump_steps = JUMP_STEPS_3;
    endcase
  end

  // Only rises count; the reference lags so slow creeps add up
  assign jump_hit = write_now && wb_adr_i == ADR_BRIGHTNESS
    && next_brightness > brightness_ref
    && (next_brightness - brightness_ref) > thres
    && cfg.jump_enable && adaptive_on;
  assign jump_sum = {1'b0, setpoint_o} + {1'b0, jump_steps};

  // Reference follows falls and jumps, not small rises
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      brightness_ref <= 16'h0000;
    else if (write_now && wb_adr_i == ADR_BRIGHTNESS)
    begin
      if (jump_hit || next_brightness < brightness_ref)
        brightness_ref <= next_brightness;
    end
  end

  // ------------------------------------------------------------
  // Adaptive step pacing
  // ------------------------------------------------------------
  // Paced so the analog loop settles between fine steps
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !adaptive_on)
      adapt_count <= 8'h00;
    else if (adapt_count == ADAPT_LAST)
      adapt_count <= 8'h00;
    else
      adapt_count <= adapt_count + 8'h01;
  end

  assign adapt_tick = adaptive_on && adapt_count == ADAPT_LAST;

  // ------------------------------------------------------------
  // Setpoint
  // ------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      adaptive_active_o <= 1'b0;
    else
      adaptive_active_o <= adaptive_on;
  end

  // Fixed mode follows the code; adaptive starts from it
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      setpoint_o <= 8'h00;
    else if (!adaptive_on)
      setpoint_o <= start_point;
    else if (!adaptive_active_o)
      setpoint_o <= start_point;
    else if (jump_hit)
    begin
      if (jump_sum > {1'b0, SETPOINT_MAX})
        setpoint_o <= SETPOINT_MAX;
      else
        setpoint_o <= jump_sum[7:0];
    end
    else if (adapt_tick)
    begin
      // Weakest string wins: any low lifts, all high lowers
      if (any_low && setpoint_o < SETPOINT_MAX)
        setpoint_o <= setpoint_o + 8'h01;
      else if (!any_low && all_high && setpoint_o != 8'h00)
        setpoint_o <= setpoint_o - 8'h01;
    end
  end

  // Jump strobe, one cycle per accepted jump
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      jump_o <= 1'b0;
    else
      jump_o <= jump_hit & adaptive_active_o;
  end

  // ------------------------------------------------------------
  // Gate driver strength
  // ------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      drive_enable_o <= DRIVE_0;
    else
    begin
      unique case (cfg.driver_size)
        2'b00: drive_enable_o <= DRIVE_0;
        2'b01: drive_enable_o <= DRIVE_1;
        2'b10: drive_enable_o <= DRIVE_2;
        2'b11: drive_enable_o <= DRIVE_3;
      endcase
    end
  end

endmodule

`default_nettype wire

// file: verification/boost_jump_sva.sv
`timescale 1ns/1ns
`default_nettype none
// ----
// Checker
// ----
module boost_jump_sva
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic [7:0] setpoint_o,
  input wire logic adaptive_active_o,
  input wire logic jump_o,
  input wire logic [2:0] drive_enable_o
);
  import boost_jump_pkg::*;
  logic [7:0] cfg;
  logic [5:0] init_q;
  logic [3:0] clus;
  logic [3:0] quiet;
  logic wr;
  // A write lands at the ack edge
  assign wr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];
  // Shadow copies, since the checker cannot see the registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cfg <= 8'h00;
      init_q <= 6'h00;
      clus <= 4'h0;
    end
    else if (wr && wb_adr_i == ADR_CONFIG)
      cfg <= wb_dat_i[7:0];
    else if (wr && wb_adr_i == ADR_INITIAL)
      init_q <= wb_dat_i[5:0];
    else if (wr && wb_adr_i == ADR_CLUSTER)
      clus <= wb_dat_i[3:0];
  end
  // Cycles since the last write; outputs lag, so wait them out
  always_ff @(posedge clk_i)
    quiet <= (rst_i || wr) ? 4'h0 : quiet + 4'(quiet != 4'hf);
  function automatic logic [7:0] sat_add(input logic [7:0] a,
    input logic [7:0] b);
    return ({1'b0, a} + {1'b0, b} > 9'h0fc) ? SETPOINT_MAX : a + b;
  endfunction
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  AST_ACK_LAT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  AST_DRIVE: assert property (wr && wb_adr_i == ADR_CONFIG |-> ##2
    drive_enable_o == 3'((4'h1 << cfg[7:6]) - 4'h1))
    else $error("drive code");
  AST_FIXED: assert property ((!adaptive_active_o && quiet > 4'h3) [*3]
    |-> setpoint_o == {init_q, 2'b00})
    else $error("fixed setpoint");
  AST_CLUSTER: assert property (clus == 4'hf && quiet > 4'h2
    |-> !adaptive_active_o)
    else $error("cluster adaptive");
  AST_ADAPT: assert property (cfg[5] && clus != 4'hf && quiet > 4'h2
    |-> adaptive_active_o)
    else $error("adaptive off");
  AST_JUMP_CAUSE: assert property (jump_o |-> cfg[4] &&
    $past(wr && wb_adr_i == ADR_BRIGHTNESS))
    else $error("jump cause");
  AST_JUMP_ONE: assert property (jump_o |=> !jump_o)
    else $error("jump pulse");
  AST_JUMP_SIZE: assert property (jump_o |->
    setpoint_o == sat_add($past(setpoint_o), 8'h08 << cfg[1:0]))
    else $error("jump size");
  AST_SET_MAX: assert property (setpoint_o <= SETPOINT_MAX)
    else $error("setpoint high");
endmodule
bind boost_jump_ctrl boost_jump_sva i_sva
(
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .setpoint_o(setpoint_o),
  .adaptive_active_o(adaptive_active_o), .jump_o(jump_o),
  .drive_enable_o(drive_enable_o)
);
`default_nettype wire

// file: verification/led_string_model.sv
`timescale 1ns/1ns
`default_nettype none
// ----
// Boost stage and four LED strings
// ----
module led_string_model
(
  input wire logic [7:0] setpoint_i,
  input wire logic [7:0] need_i,
  input wire logic [7:0] margin_i,
  output logic [3:0] low_o,
  output logic [3:0] high_o
);
  // String k needs k fine steps less; the top string sets the floor
  always_comb
  begin
    for (int k = 0; k < 4; k++)
    begin
      low_o[k] = {1'b0, setpoint_i} < 9'(need_i) - 9'(k);
      high_o[k] = {1'b0, setpoint_i} > 9'(need_i) + 9'(margin_i) - 9'(k);
    end
  end
endmodule
`default_nettype wire

// file: verification/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  import boost_jump_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o, q;
  logic wb_ack_o, adaptive_active_o, jump_o;
  logic [3:0] low, high;
  logic [7:0] setpoint_o, sp, d;
  logic [7:0] need = 8'h00;
  logic [7:0] margin = 8'h02;
  logic [2:0] drive_enable_o;
  logic [5:0] init;
  logic [1:0] s;
  int failures = 0;
  int total_checks = 0;
  int cycles = 0;
  // ----
  // Clock, hang guard, design and far side
  // ----
  initial
    forever #20 clk_i = ~clk_i;
  // A few thousand cycles is ample; beyond that something hung
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      failures++;
      summarize();
    end
  end
  boost_jump_ctrl i_dut
  (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .headroom_low_i(low), .headroom_high_i(high), .setpoint_o(setpoint_o),
    .adaptive_active_o(adaptive_active_o), .jump_o(jump_o),
    .drive_enable_o(drive_enable_o)
  );
  led_string_model i_model
  (
    .setpoint_i(setpoint_o), .need_i(need), .margin_i(margin),
    .low_o(low), .high_o(high)
  );
  // ----
  // Helpers
  // ----
  task automatic summarize;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // One classic cycle; returns one edge after release
  task automatic bus(input logic we, input logic [7:0] a,
    input logic [31:0] dat);
    // No local limit: a missing ack is left to the cycle guard
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'hf;
    wb_dat_i <= dat;
    do
      @(posedge clk_i);
    while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  function automatic logic [7:0] sat(input logic [7:0] a,
    input logic [7:0] b);
    return ({1'b0, a} + {1'b0, b} > 9'h0fc) ? 8'hfc : a + b;
  endfunction
  function automatic logic [15:0] thr(input int t);
    return 16'((65535 * (10 + 20 * t)) / 100);
  endfunction
  // Brightness write, then the jump pulse and setpoint
  task automatic bw(input logic [15:0] v, input logic j);
    bus(1'b1, ADR_BRIGHTNESS, {16'h0, v});
    if (j)
      sp = sat(sp, 8'h08 << s);
    chk(jump_o, j);
    chk(setpoint_o, sp);
  endtask
  // ----
  // Scenarios
  // ----
  initial
  begin
    void'($urandom(32'ha706));
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int c = 0; c < 4; c++)
    begin
      d = {2'(c), 1'b0, 5'($urandom)};
      bus(1'b1, ADR_CONFIG, {24'h0, d});
      bus(1'b0, ADR_CONFIG, 32'h0);
      chk(q, {24'h0, d});
      chk(drive_enable_o, 3'((4'h1 << c) - 4'h1));
    end
    bus(1'b0, 8'h40, 32'h0);
    chk(q, 32'h0);
    init = 6'(30 + $urandom % 10);
    bus(1'b1, ADR_INITIAL, {26'h0, init});
    repeat (3) @(posedge clk_i);
    chk(setpoint_o, {init, 2'b00});
    need <= {init, 2'b00} + 8'h0c;
    bus(1'b1, ADR_CLUSTER, 32'hf);
    bus(1'b1, ADR_CONFIG, 32'h30);
    repeat (40) @(posedge clk_i);
    chk(adaptive_active_o, 1'b0);
    chk(setpoint_o, {init, 2'b00});
    bus(1'b1, ADR_CLUSTER, 32'h7);
    repeat (600) @(posedge clk_i);
    chk(adaptive_active_o, 1'b1);
    chk(setpoint_o, need);
    // Strings stop asking for less, so jumps stand still
    margin <= 8'hff;
    sp = need;
    for (int i = 0; i < 6; i++)
    begin
      s = (i > 3) ? 2'd3 : 2'($urandom);
      bus(1'b1, ADR_CONFIG, {26'h0, 2'b11, 2'(i), s});
      bw(16'h0000, 1'b0);
      bw(thr(i % 4), 1'b0);
      bw(thr(i % 4) + 16'h1, 1'b1);
    end
    bus(1'b1, ADR_CONFIG, 32'h20);
    bw(16'h0000, 1'b0);
    bw(16'hffff, 1'b0);
    // Status word: no jump pending, adaptive on, setpoint as tracked
    bus(1'b0, ADR_STATUS, 32'h0);
    chk(q, {22'h0, 2'h1, sp});
    // Adaptive off while strings ask for more: code holds, no jumps
    bus(1'b1, ADR_CONFIG, 32'h10);
    sp = {init, 2'b00};
    repeat (60) @(posedge clk_i);
    chk(adaptive_active_o, 1'b0);
    bw(16'h0000, 1'b0);
    bw(16'hffff, 1'b0);
    summarize();
  end
endmodule
`default_nettype wire
